// File: rtl/mtp_consts.vh
// Register offsets, field positions, reset values and modes of the timer
`ifndef MTP_CONSTS_VH
`define MTP_CONSTS_VH

// Register byte addresses, one aligned word each
`define MTP_ADDR_W 5
`define MTP_OFS_CTRL 5'h00
`define MTP_OFS_COUNT_LO 5'h04
`define MTP_OFS_COUNT_HI 5'h08
`define MTP_OFS_RA_LO 5'h0C
`define MTP_OFS_RA_HI 5'h10
`define MTP_OFS_RB_LO 5'h14
`define MTP_OFS_RB_HI 5'h18
`define MTP_OFS_PIN 5'h1C

// Control register fields
`define MTP_BIT_MODE_HI 7
`define MTP_BIT_MODE_MID 6
`define MTP_BIT_EDGE 5
`define MTP_BIT_RUN 4
`define MTP_BIT_PEND 3
`define MTP_BIT_IRQEN 2
`define MTP_BIT_CAPTYPE 1
`define MTP_BIT_ALTRLD 0

// Mode codes on the two upper mode bits
`define MTP_MODE_EVENT 2'b00
`define MTP_MODE_CAPTURE 2'b01
`define MTP_MODE_PWM 2'b10
`define MTP_MODE_DIFF 2'b11

// Reset values
`define MTP_RST_COUNT 16'hFFFF
`define MTP_RST_RELOAD 16'h0000
`define MTP_RST_CTRL 8'h00
`define MTP_RST_PIN 1'b0

// Count boundaries
`define MTP_COUNT_ZERO 16'h0000
`define MTP_COUNT_ONE 16'h0001
`define MTP_COUNT_MAX 16'hFFFF

`endif

// File: rtl/mtp_pin_sync.v
// Two-flop synchroniser and edge detector for the timer pin input
module mtp_pin_sync (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Pin side
  input wire pin_in,
  // Synchronised edges, one-cycle pulses
  output wire rise,
  output wire fall
);

  reg sync1;
  reg sync2;
  reg prev;

  // Idle level high, as with the pin pull-up
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      prev <= 1'b1;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign rise = sync2 & ~prev;
  assign fall = ~sync2 & prev;

endmodule

// File: rtl/mtp_apb_port.v
// APB slave front end: decode, strobes and error answer
`include "mtp_consts.vh"
module mtp_apb_port (
  // APB request
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [3:0] pstrb,
  // APB answer
  output wire pready,
  output wire pslverr,
  // Decoded strobes
  output wire setup,
  output wire wr_byte,
  output wire mapped
);

  wire [`MTP_ADDR_W-1:0] ofs;

  assign ofs = paddr[`MTP_ADDR_W-1:0];
  // Only the low byte lane carries register data
  assign mapped = (paddr[31:`MTP_ADDR_W] == 27'h0000000) &&
                  (ofs[1:0] == 2'b00) && (ofs <= `MTP_OFS_PIN);
  // Zero wait states keep the timer bus-agnostic
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign setup = psel & ~penable;
  assign wr_byte = psel & penable & pwrite & mapped & pstrb[0];

endmodule

// File: rtl/mtp_timer.v
// Multimode 16-bit timer with PWM, event counting and capture

`include "mtp_consts.vh"

module mtp_timer (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Core interrupt
  input wire global_irq_enable,
  output wire timer_interrupt,
  // Timer pin
  input wire timer_pin_in,
  output wire timer_pin_out,
  output wire timer_pin_oe_n
);

  localparam DIFF_WAIT = 1'b0;
  localparam DIFF_COUNT = 1'b1;

  reg [7:0] timer_control_reg;
  reg [15:0] count_register;
  reg [15:0] reload_capture_a;
  reg [15:0] reload_b;
  reg pin_level;
  reg use_b;
  reg diff_state;

  wire setup;
  wire wr_byte;
  wire mapped;
  wire pin_rise;
  wire pin_fall;
  wire [7:0] wbyte;
  wire [`MTP_ADDR_W-1:0] ofs;
  wire [1:0] mode;
  wire is_event;
  wire is_pwm;
  wire is_cap;
  wire is_diff;
  wire run_or_underflow_flag;
  wire edge_or_toggle_select;
  wire alternate_reload_enable;
  wire sel_edge;
  wire opp_edge;
  wire end_edge;
  wire tick;
  wire at_zero;
  wire underflow;
  wire [15:0] reload_value;
  wire [15:0] count_dec;
  wire [15:0] count_inc;
  reg [7:0] rd_byte;

  // Decode kept apart so wait states can be added in one place
  mtp_apb_port u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pstrb(pstrb),
    .pready(pready),
    .pslverr(pslverr),
    .setup(setup),
    .wr_byte(wr_byte),
    .mapped(mapped)
  );

  // Pin edges reach the counter three clocks after the pin moves
  mtp_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(timer_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign wbyte = pwdata[7:0];
  assign ofs = paddr[`MTP_ADDR_W-1:0];

  // Mode decode from the stored control byte only
  assign mode = timer_control_reg[`MTP_BIT_MODE_HI:`MTP_BIT_MODE_MID];
  assign is_event = (mode == `MTP_MODE_EVENT);
  assign is_pwm = (mode == `MTP_MODE_PWM);
  assign is_cap = (mode == `MTP_MODE_CAPTURE);
  assign is_diff = (mode == `MTP_MODE_DIFF);
  assign run_or_underflow_flag = timer_control_reg[`MTP_BIT_RUN];
  assign edge_or_toggle_select = timer_control_reg[`MTP_BIT_EDGE];
  assign alternate_reload_enable = timer_control_reg[`MTP_BIT_ALTRLD];

  // Edge select: zero positive, one negative
  assign sel_edge = edge_or_toggle_select ? pin_fall : pin_rise;
  assign opp_edge = edge_or_toggle_select ? pin_rise : pin_fall;
  // Pulse ends on the opposite edge, cycle on the same edge
  assign end_edge = timer_control_reg[`MTP_BIT_CAPTYPE] ?
                    sel_edge : opp_edge;

  // Counting source per mode; synchronised edges cap the rate at half clock
  assign tick = (is_pwm & run_or_underflow_flag) |
                (is_event & run_or_underflow_flag & sel_edge) |
                is_cap;
  assign at_zero = (count_register == `MTP_COUNT_ZERO);
  // Underflow only when a tick finds zero, never on reaching it
  assign underflow = tick & at_zero & ~is_diff;

  // Second source only in PWM with alternation on
  assign reload_value = (is_pwm & alternate_reload_enable & use_b) ?
                        reload_b : reload_capture_a;
  assign count_dec = count_register - `MTP_COUNT_ONE;
  assign count_inc = count_register + `MTP_COUNT_ONE;

  // A level, not a pulse: it falls when pending and, in capture modes, the run flag are cleared or either enable drops
  assign timer_interrupt = global_irq_enable &
                           timer_control_reg[`MTP_BIT_IRQEN] &
                           (timer_control_reg[`MTP_BIT_PEND] |
                            ((is_cap | is_diff) & run_or_underflow_flag));

  // Pin driven only in PWM; low enable means driving
  assign timer_pin_oe_n = ~is_pwm;
  assign timer_pin_out = pin_level;

  // Control byte, flags and counter
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_reg <= `MTP_RST_CTRL;
      count_register <= `MTP_RST_COUNT;
      reload_capture_a <= `MTP_RST_RELOAD;
      reload_b <= `MTP_RST_RELOAD;
      pin_level <= `MTP_RST_PIN;
      use_b <= 1'b0;
      diff_state <= DIFF_WAIT;
    end
    else
    begin
      // Hardware counting, software writes below override the count
      if (is_diff)
      begin
        // Counts up from the first selected edge to the closing edge
        case (diff_state)
          DIFF_WAIT:
          begin
            if (sel_edge)
            begin
              count_register <= `MTP_COUNT_ZERO;
              diff_state <= DIFF_COUNT;
            end
          end
          DIFF_COUNT:
          begin
            if (end_edge)
            begin
              reload_capture_a <= count_register;
              diff_state <= DIFF_WAIT;
            end
            else
            begin
              count_register <= count_inc;
            end
          end
          default:
          begin
            diff_state <= DIFF_WAIT;
          end
        endcase
      end
      else
      begin
        diff_state <= DIFF_WAIT;
        if (underflow)
        begin
          count_register <= reload_value;
        end
        else if (tick)
        begin
          count_register <= count_dec;
        end
        // Standard capture copies the running count, which keeps going
        if (is_cap && sel_edge)
        begin
          reload_capture_a <= count_register;
        end
      end

      // Alternation restarts on the first register whenever stopped
      if (!(is_pwm && run_or_underflow_flag))
      begin
        use_b <= 1'b0;
      end
      else if (underflow && alternate_reload_enable)
      begin
        use_b <= ~use_b;
      end

      // Software writes, one byte per register
      // A count byte written here beats the hardware step of this cycle
      if (wr_byte)
      begin
        case (ofs)
          `MTP_OFS_CTRL: timer_control_reg <= wbyte;
          `MTP_OFS_COUNT_LO: count_register[7:0] <= wbyte;
          `MTP_OFS_COUNT_HI: count_register[15:8] <= wbyte;
          `MTP_OFS_RA_LO: reload_capture_a[7:0] <= wbyte;
          `MTP_OFS_RA_HI: reload_capture_a[15:8] <= wbyte;
          `MTP_OFS_RB_LO: reload_b[7:0] <= wbyte;
          `MTP_OFS_RB_HI: reload_b[15:8] <= wbyte;
          `MTP_OFS_PIN: pin_level <= wbyte[0];
          default: pin_level <= pin_level;
        endcase
      end

      // Pin toggles on the same edge that sets pending
      if (is_pwm && underflow && edge_or_toggle_select)
      begin
        pin_level <= ~pin_level;
      end

      // Hardware sets after the write so a same-cycle clear cannot lose it
      if ((underflow && !is_cap) ||
          (is_cap && sel_edge) ||
          (is_diff && diff_state == DIFF_COUNT && end_edge))
      begin
        timer_control_reg[`MTP_BIT_PEND] <= 1'b1;
      end
      // Capture modes reuse the run bit as underflow flag, as overflow flag in diff mode
      if ((is_cap && underflow) ||
          (is_diff && diff_state == DIFF_COUNT && !end_edge &&
           count_register == `MTP_COUNT_MAX))
      begin
        timer_control_reg[`MTP_BIT_RUN] <= 1'b1;
      end
    end
  end

  // Read mux; narrow registers sit in the low byte
  // Sixteen-bit values are read live, so a running count may tear
  always @*
  begin
    rd_byte = 8'h00;
    case (ofs)
      `MTP_OFS_CTRL: rd_byte = timer_control_reg;
      `MTP_OFS_COUNT_LO: rd_byte = count_register[7:0];
      `MTP_OFS_COUNT_HI: rd_byte = count_register[15:8];
      `MTP_OFS_RA_LO: rd_byte = reload_capture_a[7:0];
      `MTP_OFS_RA_HI: rd_byte = reload_capture_a[15:8];
      `MTP_OFS_RB_LO: rd_byte = reload_b[7:0];
      `MTP_OFS_RB_HI: rd_byte = reload_b[15:8];
      `MTP_OFS_PIN: rd_byte = {7'h00, pin_level};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data captured in setup so it stands through the access phase;
  // a counter value is thus one cycle old when the transfer completes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (setup && !pwrite)
    begin
      prdata <= mapped ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

endmodule

// File: tb/mtp_timer_checker.sv
// Port-level assertions for the multimode timer
module mtp_timer_checker (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  // Interrupt and pin
  input logic global_irq_enable,
  input logic timer_interrupt,
  input logic timer_pin_out,
  input logic timer_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] c_q;
  wire wr = psel && penable && pwrite && pstrb[0];
  wire wr_c = wr && paddr == 32'h0;
  wire wr_p = wr && paddr == 32'h1C;
  wire irq = timer_interrupt;
  wire gie = global_irq_enable;
  // Software view only; hardware-set flags are not tracked
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      c_q <= 8'h00;
    else if (wr_c)
      c_q <= pwdata[7:0];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_gie_gate: assert property (!gie |-> !irq)
    else $error("irq without global enable");
  a_en_mask: assert property (wr_c && !pwdata[2] |=> !irq)
    else $error("irq while masked");
  a_pend_raise: assert property (
    wr_c && pwdata[3:2] == 2'b11 ##1 gie |-> irq)
    else $error("written pending gives no irq");
  a_irq_hold: assert property (irq && !wr_c ##1 gie |-> irq)
    else $error("irq dropped without clear");
  a_oe_mode: assert property (
    wr_c |=> timer_pin_oe_n == ($past(pwdata[7:6]) != 2'b10))
    else $error("pin drive wrong for mode");
  a_rd_byte: assert property (
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0 &&
    (paddr != 32'h1C || prdata[7:0] == {7'h00, $past(timer_pin_out)}))
    else $error("read wider than a byte");
  a_tog_irq: assert property ($changed(timer_pin_out) &&
    !$past(wr_p) && c_q[7:5] == 3'b101 && c_q[2] && gie |-> irq)
    else $error("toggle without irq");
  a_stop_quiet: assert property ($rose(irq) && $past(gie) &&
    !$past(wr_c) && !c_q[6] |-> c_q[4])
    else $error("underflow while stopped");
  c_tog: cover property (c_q[7:5] == 3'b101 && $changed(timer_pin_out));
  c_irq: cover property ($rose(irq));
  c_evt: cover property (c_q[7:6] == 2'b00 && c_q[4] && $rose(irq));
endmodule

bind mtp_timer mtp_timer_checker i_mtp_timer_checker (.*);

// File: tb/mtp_pin_src.sv
// Event source on the timer pin, idle high like a pull-up
module mtp_pin_src (
  // Clock and request
  input wire pclk,
  input wire start,
  input wire [7:0] n_pulses,
  input wire [3:0] half,
  // Pin and status
  output reg pin,
  output reg busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;
  int c;
  initial
  begin
    pin = 1'b1;
    busy = 1'b0;
  end
  always @(posedge pclk)
    if (start && !busy)
    begin
      busy <= 1'b1;
      k <= 2 * n_pulses;
      c <= half;
    end
    else if (busy)
      if (c > 1)
        c <= c - 1;
      else if (k == 0)
        busy <= 1'b0;
      else
      begin
        pin <= !pin; // Level held half clocks, at least one
        k <= k - 1;
        c <= half;
      end
endmodule

// File: tb/multimode_timer_pwm_event_counter_test.sv
// Self-checking bench for the multimode timer
`include "mtp_consts.vh"
module multimode_timer_pwm_event_counter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, gie, start, er;
  logic [31:0] paddr, pwdata, rd;
  logic [3:0] pstrb, half;
  logic [7:0] n_p;
  logic [15:0] lf = 16'h000C;
  wire [31:0] prdata;
  wire pready, pslverr, irq, p_out, oe_n, src, busy;
  wire pin_w = oe_n ? src : p_out;
  int error_cnt, n_checks, mdl [8], ecnt, epend, i, n;
  int exq [$];
  mtp_timer i_mtp_timer (.*, .global_irq_enable(gie),
    .timer_interrupt(irq), .timer_pin_in(pin_w),
    .timer_pin_out(p_out), .timer_pin_oe_n(oe_n));
  mtp_pin_src i_mtp_pin_src (.pclk(pclk), .start(start),
    .n_pulses(n_p), .half(half), .pin(src), .busy(busy));
  initial
  begin
    pclk = 0;
    forever #10 pclk = !pclk;
  end
  task automatic give_verdict;
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] v, logic [31:0] x);
    n_checks++;
    if (v !== x)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", s, x, v);
    end
  endtask
  function automatic logic [7:0] rnd;
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  // One APB transfer; waits for pready under a bound
  task automatic apb(bit w, logic [31:0] a, logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (w)
      mdl[a / 4] = d;
  endtask
  task automatic rchk(string s, logic [31:0] a, logic [31:0] x);
    apb(0, a, 0);
    chk(s, rd, x);
  endtask
  task automatic ld16(logic [31:0] a, logic [15:0] v);
    apb(1, a, v[7:0]);
    apb(1, a + 4, v[15:8]);
  endtask
  // Clocks to the next pin change, -1 if none within lim
  task automatic tog(int lim);
    logic p;
    p = p_out;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (p_out === p && n < lim);
    if (p_out === p)
      n = -1;
  endtask
  task automatic pulse(int k);
    int j;
    @(posedge pclk);
    start <= 1;
    n_p <= 8'(k);
    @(posedge pclk);
    start <= 0;
    j = 0;
    do
    begin
      @(posedge pclk);
      j++;
    end
    while (busy !== 1'b0 && j < 100);
    if (busy !== 1'b0)
    begin
      error_cnt++;
      give_verdict();
    end
    // Covers the pin synchroniser latency
    repeat (6) @(posedge pclk);
    repeat (k)
      if (ecnt == 0)
      begin
        ecnt = mdl[3];
        epend = 1;
      end
      else
        ecnt--;
  endtask
  initial
  begin
    {psel, penable, pwrite, gie, start} = 0;
    {paddr, pwdata} = 0;
    pstrb = 4'h1;
    half = 4'h1;
    n_p = 0;
    presetn = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 8; i++)
      rchk("reset", i * 4, (i == 1 || i == 2) ? 255 : 0);
    rchk("unmapped", 32'h20, 0);
    chk("slverr", er, 1);
    for (i = 0; i < 4; i++)
    begin
      apb(1, 0, 8'(i * 64 + 2));
      rchk("mode", 0, i * 64 + 2);
      chk("oe_n", oe_n, i != 2);
    end
    apb(1, 0, 0);
    for (i = 1; i < 7; i++)
    begin
      apb(1, i * 4, rnd());
      rchk("rw", i * 4, mdl[i]);
    end
    apb(1, `MTP_OFS_PIN, 8'hFF);
    rchk("pin", `MTP_OFS_PIN, 1);
    chk("pin out", p_out, 1);
    ld16(`MTP_OFS_RA_LO, 3);
    ld16(`MTP_OFS_RB_LO, 5);
    ld16(`MTP_OFS_COUNT_LO, 2);
    gie <= 1;
    apb(1, 0, 8'hB5);
    exq = {mdl[3] + 1, mdl[5] + 1, mdl[3] + 1};
    tog(50);
    while (exq.size() > 0)
    begin
      tog(50);
      chk("period", n, exq.pop_front());
      chk("irq", irq, 1);
    end
    apb(1, 0, 8'hA4);
    @(posedge pclk);
    tog(40);
    chk("stopped", n, -1);
    ld16(`MTP_OFS_RA_LO, 20);
    ld16(`MTP_OFS_RB_LO, 9);
    apb(1, 0, 8'hB4);
    tog(60);
    tog(60);
    chk("single", n, mdl[3] + 1);
    apb(1, 0, 8'hB4);
    @(posedge pclk);
    chk("cleared", irq, 0);
    tog(60);
    chk("raised", irq, 1);
    gie <= 0;
    @(posedge pclk);
    chk("masked", irq, 0);
    gie <= 1;
    apb(1, 0, 8'h0C);
    @(posedge pclk);
    chk("pend", irq, 1);
    rchk("ctrl", 0, 8'h0C);
    for (i = 0; i < 2; i++)
    begin
      ld16(`MTP_OFS_COUNT_LO, 2);
      ld16(`MTP_OFS_RA_LO, 2);
      apb(1, 0, i ? 8'h34 : 8'h14);
      half <= 4'(i + 1);
      ecnt = 2;
      epend = 0;
      repeat (2)
      begin
        pulse(i + 2);
        chk("evt irq", irq, epend);
        rchk("evt cnt", 4, ecnt);
      end
    end
    give_verdict();
  end
endmodule
